/* adc_cfg_assertions.sv */
/* Link checker: framing and timing of the serial configuration link.
   Assumes the host default half period of 8 pclk cycles. */
`timescale 1ns/10ps
module adc_cfg_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic serial_clock,
	input wire logic select_n,
	input wire logic host_data,
	input wire logic device_data
);
	// ======
	// Frame bit counter
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [4:0] rises;  // Rises in this frame
	logic       sclk_q; // Link clock last cycle
	// Cleared between frames so an aborted frame never carries over
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rises <= 5'h00;
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= serial_clock;
			if (select_n) rises <= 5'h00;
			else if (serial_clock && !sclk_q) rises <= rises + 5'h01;
		end
	end
	// ======
	// Link properties
	chk_idle_clock_low: assert property (select_n |-> !serial_clock)
		else $error("link clock runs outside a frame");
	chk_idle_data_zero: assert property (select_n && $past(select_n, 8) |-> !device_data)
		else $error("device data not idle");
	chk_lead_low: assert property ($fell(select_n) |-> !serial_clock [*8])
		else $error("link clock rose too early");
	chk_high_half: assert property ($rose(serial_clock) |-> serial_clock [*8] ##1 !serial_clock)
		else $error("high half period wrong");
	chk_low_half: assert property ($fell(serial_clock) |-> !serial_clock [*8])
		else $error("low half period short");
	chk_host_data_hold: assert property (serial_clock && $past(serial_clock) |-> $stable(host_data))
		else $error("host data moved while clock high");
	chk_frame_gap: assert property ($rose(select_n) |-> select_n [*8])
		else $error("frame gap too short");
	chk_frame_bits: assert property ($rose(select_n) |-> rises == 5'h10)
		else $error("frame not sixteen bits");
	chk_read_bit_phase: assert property ($changed(device_data) && rises < 5'h10 |-> serial_clock)
		else $error("read bit changed while clock low");
	cover property ($rose(select_n));
	cover property ($rose(device_data));
	cover property (rises == 5'h10);
endmodule : adc_cfg_assertions

/* adc_cfg_device.sv */
/*
 * Device end: configuration bank reached over the serial link, plus the
 * sync, reference, test-pattern and output-format decode it steers.
 * Assumes the host frames 16 bits (rw, 7 address, 8 data) MSB first,
 * changes data while the link clock is low, and keeps each half period
 * at least six pclk cycles long.
 */
`timescale 1ns/10ps
`include "adc_cfg_map.svh"
module adc_cfg_device import adc_cfg_pkg::*; #(
	parameter bit FASTEST_GRADE = 1'b1   // Fastest speed grade fitted
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	adc_cfg_if.device        link,
	input  wire logic        sync_powerdown_pin,
	input  wire logic        reference_buffer_pin,
	input  wire logic        sample_tick,
	input  wire logic        decimation_bypass,
	input  wire logic        serial_clock_companion_en,
	input  wire logic [17:0] conv_data_a,
	input  wire logic [17:0] conv_data_b,
	output logic             global_powerdown,
	output logic             sync_pulse,
	output logic [1:0]       reference_mode,
	output logic             single_ended_clock,
	output logic             diff_clock_buffer_pd,
	output logic             single_ended_input_a,
	output logic             single_ended_input_b,
	output logic             delay_loop_powerdown,
	output logic             auto_zero_enable,
	output logic             fuse_load_pulse,
	output logic [17:0]      test_word_a,
	output logic [17:0]      test_word_b,
	output logic             serial_clock_buffer_on,
	output logic             frame_clock_source,
	output logic             frame_clock_divide,
	output logic             frame_pin_is_frame_clock,
	output logic             frame_clock_stretch,
	output logic [4:0]       output_width,
	output logic [1:0]       output_clock_delay
);
	// ==========================================================
	// Helpers
	function automatic cfg_byte_t mask_of(input cfg_addr_t a);
		case (a)
			`A_SOFT_RESET: mask_of = `M_SOFT_RESET;
			`A_SYNC_REF:   mask_of = `M_SYNC_REF;
			`A_ANALOG_IN:  mask_of = `M_ANALOG_IN;
			`A_FUSE_LOAD:  mask_of = `M_FUSE_LOAD;
			`A_PAT_LOW:    mask_of = `M_FULL;
			`A_PAT_MID:    mask_of = `M_FULL;
			`A_PAT_SEL:    mask_of = `M_FULL;
			`A_SCLK_IN:    mask_of = `M_SCLK_IN;
			`A_FRAME_CLK:  mask_of = `M_FRAME_CLK;
			`A_MAPPER:     mask_of = `M_MAPPER;
			`A_CLK_DELAY:  mask_of = `M_CLK_DELAY;
			default:       mask_of = `RST_BYTE;
		endcase
	endfunction : mask_of

	// Auto-zero default depends on the grade
	function automatic cfg_byte_t default_of(input int a);
		default_of = (a == int'(`A_ANALOG_IN) && !FASTEST_GRADE) ? `AZ_ON_BYTE
		                                                          : `RST_BYTE;
	endfunction : default_of

	// Normal data, ramp or constant, before the mapper
	function automatic logic [17:0] pattern_of(input logic [2:0] sel,
	                                           input logic [17:0] ramp,
	                                           input logic [17:0] conv,
	                                           input logic [17:0] custom);
		case (sel)
			`PAT_RAMP:  pattern_of = ramp;
			`PAT_CONST: pattern_of = custom;
			default:    pattern_of = conv;
		endcase
	endfunction : pattern_of

	// ==========================================================
	// Pin synchronisation
	logic [4:0] synced;       // clk, sel_n, mosi, sync pin, ref pin
	logic       s_clk;        // Synced link clock
	logic       s_sel_n;      // Synced select
	logic       s_mosi;       // Synced host data
	logic       s_sync_pin;   // Synced sync/power-down pin
	logic       s_ref_pin;    // Synced reference pin
	logic       clk_d;        // Previous link clock
	logic       pin_d;        // Previous sync pin
	link_sync #(.WIDTH(5)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({link.serial_clock, link.select_n, link.host_data,
		            sync_powerdown_pin, reference_buffer_pin}),
		.sync_out (synced)
	);
	assign {s_clk, s_sel_n, s_mosi, s_sync_pin, s_ref_pin} = synced;

	// ==========================================================
	// Frame receiver
	logic [15:0] rx;          // Incoming shift
	logic [4:0]  bit_cnt;     // Rising edges this frame
	logic        frame_rw;    // Latched direction, 1 = read
	cfg_addr_t   frame_addr;  // Latched address
	cfg_byte_t   tx;          // Read data shift
	cfg_byte_t   bank [0:31]; // Low 32 offsets; unmapped masked off
	wire         rise     = s_clk & ~clk_d;
	wire [15:0]  rx_next  = {rx[14:0], s_mosi};
	wire         hdr_done = rise & ~s_sel_n & (bit_cnt == `HDR_BITS - 5'd1);
	wire         commit   = rise & ~s_sel_n & ~frame_rw
	                        & (bit_cnt == `FRAME_BITS - 5'd1);
	wire cfg_byte_t wdata = rx_next[7:0];

	// Shift in, latch header, shift read data out on rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_d <= 1'b0; rx <= '0; bit_cnt <= '0;
			frame_rw <= 1'b0; frame_addr <= '0; tx <= '0;
		end else begin
			clk_d <= s_clk;
			if (s_sel_n) begin            // Idle: frame restarts
				bit_cnt <= '0;
				tx      <= '0;
			end else if (rise) begin
				rx      <= rx_next;
				bit_cnt <= bit_cnt + 5'd1;
				if (hdr_done) begin
					frame_rw   <= rx_next[7];
					frame_addr <= rx_next[6:0];
					tx         <= rx_next[7] ? bank[rx_next[4:0]] & mask_of(rx_next[6:0])
					                         : `RST_BYTE;
				end else begin
					tx <= {tx[6:0], 1'b0};
				end
			end
		end
	end
	assign link.device_data = tx[7];

	// ==========================================================
	// Register bank
	wire in_range   = (frame_addr[6:5] == 2'b00);
	wire soft_reset = commit & (frame_addr == `A_SOFT_RESET) & wdata[0];
	wire fuse_done  = commit & (frame_addr == `A_FUSE_LOAD)
	                  & bank[5'h13][0] & ~wdata[0];

	// Soft reset and fuse load both restore defaults; reset bit never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++) begin
				bank[i] <= default_of(i);
			end
		end else if (soft_reset || fuse_done) begin
			for (int i = 0; i < 32; i++) begin
				bank[i] <= default_of(i);
			end
		end else if (commit && in_range && frame_addr != `A_SOFT_RESET) begin
			bank[frame_addr[4:0]] <= wdata & mask_of(frame_addr);
		end
	end

	// ==========================================================
	// Field decode
	wire cfg_byte_t sr  = bank[5'h0E];
	wire cfg_byte_t ai  = bank[5'h11];
	wire cfg_byte_t ps  = bank[5'h16];
	wire cfg_byte_t fc  = bank[5'h19];
	wire cfg_byte_t mp  = bank[5'h1B];
	wire [17:0] custom  = {ps[1:0], bank[5'h15], bank[5'h14]};
	wire        pin_fn  = sr[`B_PIN_FUNC];
	wire        reg_en  = sr[`B_SYNC_EN];
	wire        trig    = sr[`B_SYNC_TRIG];
	wire        reference_control_source = sr[`B_REFERENCE_CONTROL_SOURCE];
	wire [2:0]  sel_a   = ps[4:2];
	wire [2:0]  sel_b   = ps[7:5];
	wire [2:0]  res     = mp[5:3];
	wire        resize  = ~decimation_bypass | mp[`B_MAP_EN];
	wire [4:0]  width_n = mp[`B_WIDE] ? 5'd20 :
	                      !resize      ? 5'd18 :
	                      (res == `RES_16) ? 5'd16 :
	                      (res == `RES_14) ? 5'd14 : 5'd18;

	// ==========================================================
	// Sync sources
	logic trig_d;    // Last seen trigger value
	logic pending;   // Sync waiting for a sample tick
	wire  trig_sync = (trig ^ trig_d) & reg_en;
	wire  pin_sync  = pin_fn & ~reg_en & s_sync_pin & ~pin_d;

	// Set beats clear; pulse lands on a sample tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_d <= 1'b0; pin_d <= 1'b0; pending <= 1'b0; sync_pulse <= 1'b0;
		end else begin
			trig_d     <= trig;
			pin_d      <= s_sync_pin;
			pending    <= trig_sync | pin_sync | (pending & ~sample_tick);
			sync_pulse <= pending & sample_tick;
		end
	end

	// ==========================================================
	// Test pattern generators
	logic [17:0] ramp_a;   // Ramp accumulator A
	logic [17:0] ramp_b;   // Ramp accumulator B

	// Ramp steps by the custom value; held at zero otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_a <= '0; ramp_b <= '0; test_word_a <= '0; test_word_b <= '0;
		end else if (sample_tick) begin
			ramp_a      <= (sel_a == `PAT_RAMP) ? ramp_a + custom : '0;
			ramp_b      <= (sel_b == `PAT_RAMP) ? ramp_b + custom : '0;
			test_word_a <= pattern_of(sel_a, ramp_a, conv_data_a, custom);
			test_word_b <= pattern_of(sel_b, ramp_b, conv_data_b, custom);
		end
	end

	// ==========================================================
	// Control outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_powerdown <= 1'b0; reference_mode <= 2'b00;
			single_ended_clock <= 1'b0; diff_clock_buffer_pd <= 1'b0;
			single_ended_input_a <= 1'b0; single_ended_input_b <= 1'b0;
			delay_loop_powerdown <= 1'b0; auto_zero_enable <= 1'b0;
			fuse_load_pulse <= 1'b0; serial_clock_buffer_on <= 1'b0;
			frame_clock_source <= 1'b0; frame_clock_divide <= 1'b0;
			frame_pin_is_frame_clock <= 1'b0; frame_clock_stretch <= 1'b0;
			output_width <= 5'd18; output_clock_delay <= 2'b00;
		end else begin
			global_powerdown     <= ~pin_fn & s_sync_pin;
			// Pin low picks internal, high picks buffered external
			reference_mode       <= reference_control_source ? sr[2:1] : {1'b0, s_ref_pin};
			single_ended_clock   <= reference_control_source & sr[`B_SE_CLK];
			diff_clock_buffer_pd <= reference_control_source & sr[`B_SE_CLK];
			single_ended_input_a <= ai[`B_SE_A];
			single_ended_input_b <= ai[`B_SE_B];
			delay_loop_powerdown <= FASTEST_GRADE & ai[`B_DLL_PD];
			auto_zero_enable     <= ai[`B_AZ];
			fuse_load_pulse      <= fuse_done;
			// Both enables needed; companion lives outside this bank
			serial_clock_buffer_on <= bank[5'h18][`B_SCLK_EN]
			                          & serial_clock_companion_en;
			frame_clock_source       <= fc[`B_FC_SRC];
			frame_clock_divide       <= fc[`B_FC_DIV];
			frame_pin_is_frame_clock <= fc[`B_FC_EN];
			frame_clock_stretch      <= fc[`B_FC_STR];
			output_width             <= width_n;
			output_clock_delay       <= bank[5'h1E][5:4];
		end
	end
endmodule : adc_cfg_device

/* adc_cfg_host.sv */
/*
 * Host end: APB slave with a command and a status register; each command
 * write made while idle runs one 16-bit frame on the serial link. Software must keep the
 * device's programming order and mode constraints itself.
 * Assumes the device answers read bits within a half period of the clock.
 */
`timescale 1ns/10ps
`include "adc_cfg_map.svh"
module adc_cfg_host import adc_cfg_pkg::*; #(
	parameter int HALF = `LINK_HALF   // pclk cycles per link half period
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	adc_cfg_if.host          link
);
	// ==========================================================
	// Bus slave
	logic [15:0] cmd;        // rw, address, write data
	logic        busy;       // Frame in flight
	cfg_byte_t   read_byte;  // Last read result
	wire access   = psel & penable & pready;
	wire cmd_hit  = (paddr == `H_CMD);
	wire stat_hit = (paddr == `H_STATUS);
	// Command writes while busy are dropped
	wire start    = access & pwrite & cmd_hit & ~busy;
	wire [31:0] rd_mux = cmd_hit  ? {16'h0000, cmd} :
	                     stat_hit ? {16'h0000, read_byte, 7'h00, busy} : 32'h00000000;

	// One wait state; read data ready with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			cmd    <= '0;
		end else begin
			pready <= psel & penable & ~pready;
			prdata <= rd_mux;
			if (start) begin
				cmd <= pwdata[15:0];
			end
		end
	end

	// ==========================================================
	// Link engine
	host_state_t state;     // Frame phase
	logic [7:0]  div;       // Half-period counter
	logic [4:0]  bits;      // Bits completed
	logic [15:0] shift;     // Outgoing bits
	logic [7:0]  rx;        // Read sampling shift
	logic        s_miso;    // Synced device data
	wire         half_end = (div == 8'(HALF - 1));
	link_sync #(.WIDTH(1)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (link.device_data),
		.sync_out (s_miso)
	);

	// Data changes on the falling edge, sampled on the rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= HS_IDLE; div <= '0; bits <= '0; shift <= '0; rx <= '0;
			busy <= 1'b0; read_byte <= '0;
			link.serial_clock <= 1'b0; link.select_n <= 1'b1; link.host_data <= 1'b0;
		end else begin
			div <= half_end ? 8'h00 : div + 8'h01;
			case (state)
				HS_IDLE: begin
					div <= '0;
					if (start) begin
						busy          <= 1'b1;
						shift         <= pwdata[15:0];
						link.select_n <= 1'b0;
						state         <= HS_LEAD;
					end
				end
				HS_LEAD: if (half_end) begin
					link.host_data <= shift[15];
					bits           <= '0;
					state          <= HS_SHIFT;
				end
				HS_SHIFT: if (half_end) begin
					if (!link.serial_clock) begin
						link.serial_clock <= 1'b1;
						rx                <= {rx[6:0], s_miso};
					end else begin
						link.serial_clock <= 1'b0;
						link.host_data    <= shift[14];
						shift             <= {shift[14:0], 1'b0};
						bits              <= bits + 5'd1;
						if (bits == `FRAME_BITS - 5'd1) begin
							state <= HS_TAIL;
						end
					end
				end
				// Busy stays up one more half period so frames keep a gap
				HS_TAIL: if (half_end) begin
					if (!link.select_n) begin
						link.select_n  <= 1'b1;
						link.host_data <= 1'b0;
						read_byte      <= rx;
					end else begin
						busy  <= 1'b0;
						state <= HS_IDLE;
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end
endmodule : adc_cfg_host

/* adc_cfg_if.sv */
/*
 * Four-wire serial configuration link between host and device.
 * Assumes both ends run their own pclk; the link clock comes from the host.
 */
`timescale 1ns/10ps
interface adc_cfg_if;
	logic serial_clock;   // Host-made link clock
	logic select_n;       // Frame select, low active
	logic host_data;      // Host to device bit
	logic device_data;    // Device to host bit
	modport host   (output serial_clock, select_n, host_data, input device_data);
	modport device (input serial_clock, select_n, host_data, output device_data);
endinterface : adc_cfg_if

/* adc_cfg_map.svh */
/*
 * Register offsets, field positions, reset values and link timing for the
 * converter configuration bank and its serial host. Definitions only.
 * Assumes it is included by bare name, after which the macros are global.
 */
// Functional notes
// - Pin level: power down or sync command
// - Trigger change syncs only when enabled; sticky
// - Sync enable moves sync from pin to register
// - Reference source: pin, or select field
// - Reference code: internal, buffered, external, unused
// - Single-ended clock powers down differential buffer; both need the reference source bit set
// - Bits five/four pick single-ended inputs
// - Delay loop off halves sampling; below 40MSPS
// - Auto-zero switch; default per speed grade
// - Fuse load on one-then-zero, resets writes
// - Custom value: constant pattern or ramp step
// - Pattern select: normal, ramp, constant
// - Serial clock buffer needs companion enable too
// - Frame clock from core or decimation
// - Divide only for two-wire bypass
// - Shared pin carries frame clock or data
// - Stretch frame clock over both channels
// - Mapper enable gates resolution change in bypass
// - Wide enable selects twenty-bit output
// - Resolution code: eighteen, sixteen, fourteen
// - Output clock shift code, four steps
// - Soft reset restores defaults, self clears
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH
// ==========================================================
// Device bank offsets (7-bit link address)
`define A_SOFT_RESET   7'h00
`define A_SYNC_REF     7'h0E
`define A_ANALOG_IN    7'h11
`define A_FUSE_LOAD    7'h13
`define A_PAT_LOW      7'h14
`define A_PAT_MID      7'h15
`define A_PAT_SEL      7'h16
`define A_SCLK_IN      7'h18
`define A_FRAME_CLK    7'h19
`define A_MAPPER       7'h1B
`define A_CLK_DELAY    7'h1E
// ==========================================================
// Writable bit masks (reserved bits read zero)
`define M_SOFT_RESET   8'h01
`define M_SYNC_REF     8'hEF
`define M_ANALOG_IN    8'h35
`define M_FUSE_LOAD    8'h01
`define M_FULL         8'hFF
`define M_SCLK_IN      8'h10
`define M_FRAME_CLK    8'h93
`define M_MAPPER       8'hF8
`define M_CLK_DELAY    8'h30
// ==========================================================
// Field positions
`define B_PIN_FUNC     7
`define B_SYNC_TRIG    6
`define B_SYNC_EN      5
`define B_REFERENCE_CONTROL_SOURCE      3
`define B_SE_CLK       0
`define B_SE_A         5
`define B_SE_B         4
`define B_DLL_PD       2
`define B_AZ           0
`define B_SCLK_EN      4
`define B_FC_SRC       7
`define B_FC_DIV       4
`define B_FC_EN        1
`define B_FC_STR       0
`define B_MAP_EN       7
`define B_WIDE         6
// ==========================================================
// Codes and reset values
`define PAT_NORMAL     3'b000
`define PAT_RAMP       3'b010
`define PAT_CONST      3'b011
`define RES_18         3'b000
`define RES_16         3'b001
`define RES_14         3'b010
`define RST_BYTE       8'h00
`define AZ_ON_BYTE     8'h01
// ==========================================================
// Link framing and host register map
`define FRAME_BITS     5'd16
`define HDR_BITS       5'd8
`define LINK_HALF      8
`define H_CMD          12'h000
`define H_STATUS       12'h004
`endif

/* adc_cfg_pkg.sv */
/*
 * Types shared by both ends of the configuration link.
 * Assumes the map header supplies all numeric constants.
 */
package adc_cfg_pkg;
	// ==========================================================
	// Types
	typedef logic [7:0] cfg_byte_t;   // One bank register
	typedef logic [6:0] cfg_addr_t;   // Link address
	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_LEAD  = 2'b01,
		HS_SHIFT = 2'b11,
		HS_TAIL  = 2'b10
	} host_state_t;
endpackage : adc_cfg_pkg

/* link_sync.sv */
/*
 * Two-flop synchroniser for a bundle of unrelated levels.
 * Assumes each bit is an independent level; no word coherence.
 */
`timescale 1ns/10ps
module link_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;   // First stage, read only by second
	// ==========================================================
	// Double flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : link_sync

/* tb_adc_config_register_bank.sv */
/* Bench: APB host end and device end joined by the link interface.
   Assumes default half period and the fastest speed grade. */
`timescale 1ns/10ps
module tb_adc_config_register_bank;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, st;
	logic pready, pin = 1'b0, ref_pin = 1'b0, tick = 1'b0, byp = 1'b0, comp = 1'b1;
	logic [17:0] cva = 18'h0, cvb = 18'h0, cp, w, twa, twb;
	logic [7:0] d, rd;
	logic [1:0] tcnt = 2'h0, rmode, dly;
	logic [4:0] owid;
	logic gpd, spl, sec, dpd, sea, seb, dll, az, fpl, scb, fsrc, fdiv, fen, fstr;
	int mismatches = 0, comparisons = 0, cyc = 0, syncs = 0, fuses = 0, s0;
	localparam logic [6:0] ADDRS [10] = '{7'h0E, 7'h11, 7'h13, 7'h14, 7'h15, 7'h16, 7'h18,
		7'h19, 7'h1B, 7'h1E};
	// ======
	// Ends and checker
	adc_cfg_if link_if ();
	adc_cfg_host adc_cfg_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.link(link_if));
	adc_cfg_device adc_cfg_device_i (.pclk(pclk), .presetn(presetn), .link(link_if),
		.sync_powerdown_pin(pin), .reference_buffer_pin(ref_pin), .sample_tick(tick),
		.decimation_bypass(byp), .serial_clock_companion_en(comp), .conv_data_a(cva),
		.conv_data_b(cvb), .global_powerdown(gpd), .sync_pulse(spl), .reference_mode(rmode),
		.single_ended_clock(sec), .diff_clock_buffer_pd(dpd), .single_ended_input_a(sea),
		.single_ended_input_b(seb), .delay_loop_powerdown(dll), .auto_zero_enable(az),
		.fuse_load_pulse(fpl), .test_word_a(twa), .test_word_b(twb), .serial_clock_buffer_on(scb),
		.frame_clock_source(fsrc), .frame_clock_divide(fdiv), .frame_pin_is_frame_clock(fen),
		.frame_clock_stretch(fstr), .output_width(owid), .output_clock_delay(dly));
	adc_cfg_assertions adc_cfg_assertions_i (.pclk(pclk), .presetn(presetn),
		.serial_clock(link_if.serial_clock), .select_n(link_if.select_n),
		.host_data(link_if.host_data), .device_data(link_if.device_data));
	// ======
	// Clock, sample tick every fourth cycle, pulse counters, timeout
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
		cyc++;
		if (spl === 1'b1) syncs++;
		if (fpl === 1'b1) fuses++;
		if (cyc == 60000) begin
			mismatches++;
			give_verdict();
		end
	end
	// ======
	// Expectations: reserved bits read zero
	function automatic logic [7:0] mask(input logic [6:0] a);
		case (a)
			7'h0E: mask = 8'hEF;
			7'h11: mask = 8'h35;
			7'h18: mask = 8'h10;
			7'h19: mask = 8'h93;
			7'h1B: mask = 8'hF8;
			7'h1E: mask = 8'h30;
			default: mask = 8'hFF;
		endcase
	endfunction : mask
	function automatic logic [4:0] wid(input logic [7:0] v);
		if (v[6]) wid = 5'h14;
		else if (byp && !v[7]) wid = 5'h12;
		else if (v[5:3] == 3'b001) wid = 5'h10;
		else if (v[5:3] == 3'b010) wid = 5'h0E;
		else wid = 5'h12;
	endfunction : wid
	function automatic logic [15:0] expd(input logic [6:0] a, input logic [7:0] v);
		case (a)
			7'h0E: expd = {12'h000, v[3] ? v[2:1] : {1'b0, ref_pin}, {2{v[3] & v[0]}}};
			7'h11: expd = {12'h000, v[5], v[4], v[2], v[0]};
			7'h18: expd = {15'h0000, v[4] & comp};
			7'h19: expd = {12'h000, v[7], v[4], v[1], v[0]};
			7'h1B: expd = {11'h000, wid(v)};
			7'h1E: expd = {14'h0000, v[5:4]};
			default: expd = 16'h0000;
		endcase
	endfunction : expd
	function automatic logic [15:0] obsv(input logic [6:0] a);
		case (a)
			7'h0E: obsv = {12'h000, rmode, sec, dpd};
			7'h11: obsv = {12'h000, sea, seb, dll, az};
			7'h18: obsv = {15'h0000, scb};
			7'h19: obsv = {12'h000, fsrc, fdiv, fen, fstr};
			7'h1B: obsv = {11'h000, owid};
			7'h1E: obsv = {14'h0000, dly};
			default: obsv = 16'h0000;
		endcase
	endfunction : obsv
	// ======
	// Bus tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		st = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One link frame, then poll busy until it is done
	task automatic dev(input logic rw, input logic [6:0] a, input logic [7:0] v);
		apb(1'b1, 12'h000, {16'h0000, rw, a, v});
		do begin
			apb(1'b0, 12'h004, 32'h0);
		end while (st[0] !== 1'b0);
		rd = st[15:8];
	endtask : dev
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	// ======
	// Scenarios
	initial begin
		cp = 18'($urandom(70));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		cva <= 18'($urandom);
		cvb <= 18'($urandom);
		for (int i = 0; i < 10; i++) begin
			dev(1'b1, ADDRS[i], 8'h00);
			chk("reset", 32'(rd), 32'h0);
		end
		repeat (3) for (int i = 0; i < 10; i++) if (ADDRS[i] != 7'h13) begin
			d = 8'($urandom);
			ref_pin <= 1'($urandom);
			byp <= 1'($urandom);
			comp <= 1'($urandom);
			dev(1'b0, ADDRS[i], d);
			dev(1'b1, ADDRS[i], 8'h00);
			chk("readback", 32'(rd), 32'(d & mask(ADDRS[i])));
			d = d & mask(ADDRS[i]);
			chk("decode", 32'(obsv(ADDRS[i])), 32'(expd(ADDRS[i], d)));
			chk("decode", 32'(obsv(ADDRS[i])), 32'(expd(ADDRS[i], d)));
		end
		dev(1'b0, 7'h1E, 8'h30);
		dev(1'b0, 7'h00, 8'h01);
		dev(1'b1, 7'h1E, 8'h00);
		chk("soft reset", 32'(rd), 32'h0);
		dev(1'b1, 7'h00, 8'h00);
		chk("self clear", 32'(rd), 32'h0);
		dev(1'b0, 7'h0E, 8'h20);
		s0 = syncs;
		dev(1'b0, 7'h0E, 8'h60);
		dev(1'b0, 7'h0E, 8'h40);
		chk("reg sync", syncs, s0 + 1);
		dev(1'b0, 7'h0E, 8'h00);
		chk("sync off", syncs, s0 + 1);
		dev(1'b0, 7'h0E, 8'h80);
		pin <= 1'b1;
		repeat (12) @(posedge pclk);
		chk("pin sync", syncs, s0 + 2);
		chk("no powerdown", 32'(gpd), 32'h0);
		pin <= 1'b0;
		dev(1'b0, 7'h0E, 8'h00);
		pin <= 1'b1;
		repeat (12) @(posedge pclk);
		chk("powerdown", 32'(gpd), 32'h1);
		pin <= 1'b0;
		s0 = fuses;
		dev(1'b0, 7'h1E, 8'h30);
		dev(1'b0, 7'h13, 8'h01);
		dev(1'b0, 7'h13, 8'h00);
		chk("fuse pulse", fuses, s0 + 1);
		dev(1'b1, 7'h1E, 8'h00);
		chk("fuse reset", 32'(rd), 32'h0);
		dev(1'b0, 7'h14, cp[7:0]);
		dev(1'b0, 7'h15, cp[15:8]);
		dev(1'b0, 7'h16, {3'b000, 3'b011, cp[17:16]});
		repeat (8) @(posedge pclk);
		chk("constant", 32'(twa), 32'(cp));
		chk("normal b", 32'(twb), 32'(cvb));
		dev(1'b0, 7'h14, 8'h04);
		dev(1'b0, 7'h15, 8'h00);
		dev(1'b0, 7'h16, 8'h40);
		w = twb + 18'h00004;
		repeat (4) @(posedge pclk);
		chk("ramp step", 32'(twb), 32'(w));
		chk("normal a", 32'(twa), 32'(cva));
		dev(1'b1, 7'h12, 8'h00);
		chk("unmapped link", 32'(rd), 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("cmd readback", st, 32'h00009200);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped apb", st, 32'h0);
		give_verdict();
	end
endmodule : tb_adc_config_register_bank
